/* File: hdl/kslc_pkg.sv */
// Package of constants for the keypad scan and indicator block
package kslc_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] KSLC_KEYPAD_CONTROL_ADDR = 8'hf8;
  localparam logic [7:0] KSLC_KEYPAD_CONTROL_RST = 8'h00;
  // ==========================================================
  // Field positions
  localparam int KSLC_BIT_IRQ_FLAG = 7;
  localparam int KSLC_BIT_RESERVED = 6;
  localparam int KSLC_BIT_SCAN_EN = 5;
  localparam int KSLC_BIT_EDGE_SEL = 4;
  localparam int KSLC_LED_MSB = 3;
  // ==========================================================
  // Sizes
  localparam int KSLC_DRIVE_LINES = 20;
  localparam int KSLC_SENSE_LINES = 8;
  localparam int KSLC_LEDS = 4;
endpackage

/* File: hdl/kslc_sync2.sv */
// Two-flop synchroniser for a bus of pin inputs
module kslc_sync2 #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb
  begin
    meta_d = i_async;
    sync_d = meta_q;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign o_sync = sync_q;
endmodule

/* File: hdl/kslc_top.sv */
// Keypad matrix scan and indicator control with its control register
//
// Summary of operation
// - Control register at F8H, resets to zero
// - Scan enable: sense pullups, interrupt, LED drivers
// - Flag set by hardware only while enabled
// - Edge select: falling edge, else low level
// - Request also needs mask enable bit
// - Indicator bits active low, cleared lights
// - LEDs dark whenever scan enable clear
// - Indicator bits reset zero; set before enabling
// - Twenty drives, eight senses, four LEDs
// - Drive lines quasi-bidirectional with weak pullups
// - Drive lines share port 1,2,3 pins
// - Sense pullups off until scan enable
module kslc_top
#(
  parameter int DRIVE_LINES = kslc_pkg::KSLC_DRIVE_LINES,
  parameter int SENSE_LINES = kslc_pkg::KSLC_SENSE_LINES,
  parameter int LEDS = kslc_pkg::KSLC_LEDS
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit,
  input wire logic i_scan_irq_mask_enable,
  output logic o_scan_irq_request,
  input wire logic [DRIVE_LINES-1:0] i_drive_latch,
  input wire logic [DRIVE_LINES-1:0] i_matrix_drive_lines,
  output logic [DRIVE_LINES-1:0] o_matrix_drive_lines,
  output logic [DRIVE_LINES-1:0] o_matrix_drive_lines_oe,
  output logic [DRIVE_LINES-1:0] o_matrix_drive_pullup,
  output logic [DRIVE_LINES-1:0] o_drive_pin_level,
  input wire logic [SENSE_LINES-1:0] i_matrix_sense_lines,
  output logic [SENSE_LINES-1:0] o_sense_pullup_en,
  output logic [SENSE_LINES-1:0] o_sense_level,
  output logic [LEDS-1:0] o_led_sink_n
);
  import kslc_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic [SENSE_LINES-1:0] sense_s;
  logic [DRIVE_LINES-1:0] drive_s;

  kslc_sync2 #(.WIDTH(SENSE_LINES)) u_sense_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async(i_matrix_sense_lines),
    .o_sync(sense_s)
  );

  kslc_sync2 #(.WIDTH(DRIVE_LINES)) u_drive_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async(i_matrix_drive_lines),
    .o_sync(drive_s)
  );

  // ==========================================================
  // State and decode signals
  logic sel;
  logic wr_hit;
  logic rd_hit;
  logic any_fall;
  logic any_low;
  logic irq_event;
  logic [SENSE_LINES-1:0] sense_prev_q;
  logic [SENSE_LINES-1:0] sense_prev_d;
  logic scan_en_q;
  logic scan_en_d;
  logic edge_sel_q;
  logic edge_sel_d;
  logic [LEDS-1:0] led_off_q;
  logic [LEDS-1:0] led_off_d;
  logic [LEDS-1:0] led_sink_n_q;
  logic [LEDS-1:0] led_sink_n_d;
  logic [SENSE_LINES-1:0] sense_pullup_q;
  logic [SENSE_LINES-1:0] sense_pullup_d;
  logic irq_flag_q;
  logic irq_flag_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // ==========================================================
  // Register decode and sense line events
  always_comb
  begin
    sel = (i_sfr_addr == KSLC_KEYPAD_CONTROL_ADDR);
    wr_hit = sel && i_sfr_wr;
    rd_hit = sel && i_sfr_rd;
    sense_prev_d = sense_s;
    // Falling: high one cycle ago, low now
    any_fall = |(sense_prev_q & ~sense_s);
    any_low = ~&sense_s;
    irq_event = edge_sel_q ? any_fall : any_low;
  end

  // Idle lines sit high, so no false edge after reset
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      sense_prev_q <= '1;
    end
    else
    begin
      sense_prev_q <= sense_prev_d;
    end
  end

  // ==========================================================
  // Control fields and the drivers they gate
  always_comb
  begin
    scan_en_d = scan_en_q;
    edge_sel_d = edge_sel_q;
    led_off_d = led_off_q;
    if (wr_hit)
    begin
      scan_en_d = i_sfr_wdata[KSLC_BIT_SCAN_EN];
      edge_sel_d = i_sfr_wdata[KSLC_BIT_EDGE_SEL];
      led_off_d = i_sfr_wdata[KSLC_LED_MSB:0];
    end
    // Dark while disabled
    // Built from next values so drivers follow the write at once
    led_sink_n_d = scan_en_d ? led_off_d : {LEDS{1'b1}};
    sense_pullup_d = {SENSE_LINES{scan_en_d}};
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      scan_en_q <= KSLC_KEYPAD_CONTROL_RST[KSLC_BIT_SCAN_EN];
      edge_sel_q <= KSLC_KEYPAD_CONTROL_RST[KSLC_BIT_EDGE_SEL];
      led_off_q <= KSLC_KEYPAD_CONTROL_RST[KSLC_LED_MSB:0];
      // Drivers and pullups start off, as scan enable does
      led_sink_n_q <= '1;
      sense_pullup_q <= '0;
    end
    else
    begin
      scan_en_q <= scan_en_d;
      edge_sel_q <= edge_sel_d;
      led_off_q <= led_off_d;
      led_sink_n_q <= led_sink_n_d;
      sense_pullup_q <= sense_pullup_d;
    end
  end

  // ==========================================================
  // Interrupt flag
  always_comb
  begin
    irq_flag_d = irq_flag_q;
    // Only a write clears the flag
    if (wr_hit)
      irq_flag_d = i_sfr_wdata[KSLC_BIT_IRQ_FLAG];
    // Set only while enabled
    // Set wins over a clearing write, so no key is lost
    // Level mode sets again every cycle a line stays low
    if (scan_en_q && irq_event)
      irq_flag_d = 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      irq_flag_q <= KSLC_KEYPAD_CONTROL_RST[KSLC_BIT_IRQ_FLAG];
    end
    else
    begin
      irq_flag_q <= irq_flag_d;
    end
  end

  // ==========================================================
  // Read data, one cycle after the read strobe
  always_comb
  begin
    rdata_d = '0;
    if (rd_hit)
    begin
      rdata_d[KSLC_BIT_IRQ_FLAG] = irq_flag_q;
      rdata_d[KSLC_BIT_RESERVED] = 1'b0;
      rdata_d[KSLC_BIT_SCAN_EN] = scan_en_q;
      rdata_d[KSLC_BIT_EDGE_SEL] = edge_sel_q;
      rdata_d[KSLC_LED_MSB:0] = led_off_q;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      rdata_q <= '0;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // Outputs
  always_comb
  begin
    o_sfr_rdata = rdata_q;
    o_sfr_hit = wr_hit || rd_hit;
    o_scan_irq_request = irq_flag_q && scan_en_q && i_scan_irq_mask_enable;
    o_sense_pullup_en = sense_pullup_q;
    o_sense_level = sense_s;
    o_led_sink_n = led_sink_n_q;
    // Quasi-bidirectional: drive low only, weak pullup
    // Port pin order P1, P2, P3.5:4, P3.6, P3.7 is fixed by index
    o_matrix_drive_lines = '0;
    o_matrix_drive_lines_oe = ~i_drive_latch;
    o_matrix_drive_pullup = i_drive_latch;
    o_drive_pin_level = drive_s;
  end
endmodule

/* File: bench/kslc_properties.sv */
// Port checker for the keypad scan block
module kslc_properties (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_scan_irq_mask_enable,
  input wire logic o_scan_irq_request,
  input wire logic [19:0] i_drive_latch,
  input wire logic [19:0] o_matrix_drive_pullup,
  input wire logic [7:0] o_sense_pullup_en,
  input wire logic [7:0] o_sense_level,
  input wire logic [3:0] o_led_sink_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  wire wh = i_sfr_wr && i_sfr_addr == 8'hf8;
  wire en = o_sense_pullup_en[0];
  wire ok = en && i_scan_irq_mask_enable;
  property p_dark; !en |-> o_led_sink_n == 4'hf; endproperty
  a_dark: assert property (p_dark) else $error("led lit while off");
  property p_en; wh |=> o_sense_pullup_en == {8{$past(i_sfr_wdata[5])}}; endproperty
  a_en: assert property (p_en) else $error("pullups wrong");
  property p_led; wh && i_sfr_wdata[5] |=> o_led_sink_n == $past(i_sfr_wdata[3:0]); endproperty
  a_led: assert property (p_led) else $error("led wrong");
  property p_gate; o_scan_irq_request |-> en; endproperty
  a_gate: assert property (p_gate) else $error("request while off");
  property p_mask; !i_scan_irq_mask_enable |-> !o_scan_irq_request; endproperty
  a_mask: assert property (p_mask) else $error("request while masked");
  property p_pull; o_matrix_drive_pullup == i_drive_latch; endproperty
  a_pull: assert property (p_pull) else $error("drive pullup wrong");
  property p_flag; ok && $past(o_sense_level) == 8'hff && o_sense_level != 8'hff ##1 ok
    |-> o_scan_irq_request; endproperty
  a_flag: assert property (p_flag) else $error("no request on key");
  property p_hold; $fell(o_scan_irq_request) |-> $past(wh) || !ok; endproperty
  a_hold: assert property (p_hold) else $error("flag cleared alone");
endmodule
bind kslc_top kslc_properties u_props (
  .i_clk(i_clk),
  .i_sys_rst(i_sys_rst),
  .i_sfr_addr(i_sfr_addr),
  .i_sfr_wr(i_sfr_wr),
  .i_sfr_wdata(i_sfr_wdata),
  .i_scan_irq_mask_enable(i_scan_irq_mask_enable),
  .o_scan_irq_request(o_scan_irq_request),
  .i_drive_latch(i_drive_latch),
  .o_matrix_drive_pullup(o_matrix_drive_pullup),
  .o_sense_pullup_en(o_sense_pullup_en),
  .o_sense_level(o_sense_level),
  .o_led_sink_n(o_led_sink_n)
);

/* File: bench/kslc_keys.sv */
// Key matrix model: one key joins a drive column to a sense row
module kslc_keys (
  input wire logic [19:0] i_oe,
  input wire logic i_down,
  output logic [19:0] o_pin,
  output logic [7:0] o_sense
);
  timeunit 1ns;
  timeprecision 1ps;
  // weak pullup where not pulled low
  assign o_pin = ~i_oe;
  // Board pullups hold idle rows high; key on column 3, row 2
  assign o_sense = ~(8'(i_down && !o_pin[3]) << 2);
endmodule

/* File: bench/tb.sv */
// Self-checking bench for the keypad scan block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 0, i_sys_rst = 1, i_sfr_wr = 0, i_sfr_rd = 0, msk = 0, dn = 0, req, hit;
  logic [7:0] a = 0, d = 0, rdat, sl;
  logic [19:0] oe, pin, drv, lvl, lat = 20'hffff7;
  logic [3:0] led;
  int n_errors = 0, compares = 0, cyc = 0;
  // Written byte beside the byte read back
  logic [15:0] rows [4] = '{16'h2f2f, 16'h6a2a, 16'h0a0a, 16'h3030};
  always #2 i_clk = ~i_clk;
  kslc_keys keys (.i_oe(oe), .i_down(dn), .o_pin(pin), .o_sense(sl));
  kslc_top DUT (.i_clk, .i_sys_rst, .i_sfr_addr(a), .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata(d),
    .o_sfr_rdata(rdat), .o_sfr_hit(hit), .i_scan_irq_mask_enable(msk),
    .o_scan_irq_request(req), .i_drive_latch(lat), .i_matrix_drive_lines(pin),
    .o_matrix_drive_lines(drv), .o_matrix_drive_lines_oe(oe), .o_matrix_drive_pullup(),
    .o_drive_pin_level(lvl), .i_matrix_sense_lines(sl), .o_sense_pullup_en(),
    .o_sense_level(), .o_led_sink_n(led));
  task chk(input logic [19:0] g, e);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] v);
    @(negedge i_clk) {a, d, i_sfr_wr} = {8'hf8, v, 1'b1};
    @(negedge i_clk) i_sfr_wr = 0;
  endtask
  task rd(input logic [7:0] ad, e);
    @(negedge i_clk) {a, i_sfr_rd} = {ad, 1'b1};
    #1 chk(hit, ad == 8'hf8);
    @(negedge i_clk) i_sfr_rd = 0;
    chk(rdat, e);
  endtask
  task wrap_up(input int bump);
    n_errors += bump;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Whole run needs about 55 cycles
  always @(posedge i_clk)
    if (++cyc == 1000)
      wrap_up(1);
  initial
  begin
    repeat (5) @(negedge i_clk);
    i_sys_rst = 0;
    rd(8'hf8, 8'h00);
    chk({4'h0, led}, 8'h0f);
    rd(8'h10, 8'h00);
    foreach (rows[i])
    begin
      wr(rows[i][15:8]);
      chk(led, rows[i][13] ? rows[i][11:8] : 4'hf);
      rd(8'hf8, rows[i][7:0]);
    end
    wr(8'h20);
    {msk, dn} = 2'b11;
    repeat (4) @(negedge i_clk);
    chk(req, 1);
    dn = 0;
    rd(8'hf8, 8'ha0);
    repeat (2) @(negedge i_clk);
    wr(8'h30);
    chk(req, 0);
    {msk, dn} = 2'b01;
    repeat (4) @(negedge i_clk);
    chk(req, 0);
    msk = 1;
    #1 chk(req, 1);
    wr(8'h30);
    chk(req, 0);
    chk(drv, 20'h00000);
    chk(lvl, 20'hffff7);
    lat = 20'h7ffff;
    repeat (3) @(negedge i_clk);
    chk(oe, 20'h80000);
    chk(lvl, 20'h7ffff);
    // Mid-run reset with a key held: flag must stay clear while disabled
    lat = 20'hffff7;
    i_sys_rst = 1;
    repeat (2) @(negedge i_clk);
    i_sys_rst = 0;
    repeat (4) @(negedge i_clk);
    rd(8'hf8, 8'h00);
    chk(led, 4'hf);
    wrap_up(0);
  end
endmodule
